// ==== verilog/sfep_pkg.sv ====
// Shared constants and types of the serial flash erase and power-down sequencer.
// Assumes a 100 MHz system clock that oversamples the serial link pins.
package sfep_pkg;

   // ==========================================================
   // Opcodes and frame lengths
   // ==========================================================
   localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
   localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE   = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE   = 8'hD8;
   localparam logic [7:0] OP_ARRAY_ERASE_A   = 8'h60;
   localparam logic [7:0] OP_ARRAY_ERASE_B   = 8'hC7;
   localparam logic [7:0] OP_POWER_DOWN      = 8'hB9;
   localparam logic [7:0] OP_RELEASE_ID      = 8'hAB;
   localparam logic [5:0] OPCODE_BITS        = 6'h08;
   localparam logic [5:0] ADDR_FRAME_BITS    = 6'h20;
   localparam logic [5:0] BIT_COUNT_MAX      = 6'h3F;

   // ==========================================================
   // Array geometry
   // ==========================================================
   localparam int ARRAY_LOG2     = 21;
   localparam int SECTOR_LOG2    = 12;
   localparam int BLOCK32_LOG2   = 15;
   localparam int BLOCK64_LOG2   = 16;
   localparam int PROT_FINE_LOG2 = 12;
   localparam int PROT_WIDE_LOG2 = 16;
   localparam logic [2:0] PROT_ALL = 3'h7;

   // ==========================================================
   // Timing, figures in their own units, counts derived
   // ==========================================================
   localparam int CLK_PERIOD_NS               = 10;
   localparam int SECTOR_ERASE_TIME_US        = 50000;
   localparam int BLOCK32_ERASE_TIME_US       = 150000;
   localparam int BLOCK64_ERASE_TIME_US       = 200000;
   localparam int ARRAY_ERASE_TIME_US         = 8000000;
   localparam int POWER_DOWN_ENTRY_DELAY_NS   = 3000;
   localparam int FIRST_RELEASE_DELAY_NS      = 3000;
   localparam int SECOND_RELEASE_DELAY_NS     = 3000;
   localparam int CYCLES_PER_US = 1000 / CLK_PERIOD_NS;
   localparam int SECTOR_ERASE_CYCLES  = SECTOR_ERASE_TIME_US * CYCLES_PER_US;
   localparam int BLOCK32_ERASE_CYCLES = BLOCK32_ERASE_TIME_US * CYCLES_PER_US;
   localparam int BLOCK64_ERASE_CYCLES = BLOCK64_ERASE_TIME_US * CYCLES_PER_US;
   localparam int ARRAY_ERASE_CYCLES   = ARRAY_ERASE_TIME_US * CYCLES_PER_US;
   localparam int POWER_DOWN_ENTRY_CYCLES =
      (POWER_DOWN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIRST_RELEASE_CYCLES =
      (FIRST_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SECOND_RELEASE_CYCLES =
      (SECOND_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Arbitrary identifier value, not tied to any real part.
   localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5A;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      ERASE_SECTOR,
      ERASE_BLOCK32,
      ERASE_BLOCK64,
      ERASE_ARRAY
   } sfep_erase_kind_t;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_ENTER_PD,
      MODE_POWER_DOWN,
      MODE_RELEASE
   } sfep_mode_t;

   typedef struct packed {
      sfep_erase_kind_t kind;
      logic [23:0]      addr;
   } sfep_erase_req_t;

endpackage

// ==== verilog/sfep_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to i_clk and changes slowly against it.
`timescale 1ns/1ps
module sfep_sync #(
   parameter logic RESET_LEVEL = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_pin,
   output logic      o_level
);

   typedef struct packed {
      logic [2:0] taps;
      logic       level;
   } sfep_sync_state_t;

   sfep_sync_state_t st;
   sfep_sync_state_t next_st;

   // Shift the pin in; the level follows only when stages two and three agree.
   always_comb begin
      next_st = st;
      next_st.taps = {st.taps[1:0], i_pin};
      if (st.taps[1] == st.taps[2]) begin
         next_st.level = st.taps[2];
      end
   end

   // Register the state.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st <= '{taps: {3{RESET_LEVEL}}, level: RESET_LEVEL};
      end else begin
         st <= next_st;
      end
   end

   assign o_level = st.level;

endmodule

// ==== verilog/sfep_timer.sv ====
// Loadable down-counter that times one self-timed interval.
// Assumes the load pulse comes from logic on the same clock.
`timescale 1ns/1ps
module sfep_timer #(
   parameter int W = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_count,
   output logic              o_busy,
   output logic              o_done
);

   typedef struct packed {
      logic [W-1:0] remaining;
      logic         busy;
      logic         done;
   } sfep_timer_state_t;

   sfep_timer_state_t st;
   sfep_timer_state_t next_st;

   // Count down while busy and pulse done for one cycle on expiry.
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (i_load) begin
         next_st.remaining = i_count;
         next_st.busy = 1'b1;
      end else if (st.busy) begin
         if (st.remaining <= W'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.remaining = '0;
         end else begin
            next_st.remaining = st.remaining - W'(1);
         end
      end
   end

   // Register the state.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_busy = st.busy;
   assign o_done = st.done;

endmodule

// ==== verilog/sfep_ctrl.sv ====
// Erase and power-state command sequencer of a serial NOR flash, device side.
// Assumes the host is the link master; pins are oversampled by i_clk.
`timescale 1ns/1ps
module sfep_ctrl #(
   parameter int         SECTOR_CYCLES  = sfep_pkg::SECTOR_ERASE_CYCLES,
   parameter int         BLOCK32_CYCLES = sfep_pkg::BLOCK32_ERASE_CYCLES,
   parameter int         BLOCK64_CYCLES = sfep_pkg::BLOCK64_ERASE_CYCLES,
   parameter int         ARRAY_CYCLES   = sfep_pkg::ARRAY_ERASE_CYCLES,
   parameter logic [7:0] DEVICE_ID      = sfep_pkg::DEVICE_ID_DEFAULT
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_resetn,
   input  wire logic                     i_sclk,
   input  wire logic                     i_cs_n,
   input  wire logic                     i_si,
   output logic                          o_so,
   output logic                          o_so_oe,
   input  wire logic [4:0]               i_protect_bits,
   input  wire logic                     i_ext_busy,
   output logic                          o_write_enable_latch,
   output logic                          o_in_progress_flag,
   output logic                          o_erase_start,
   output sfep_pkg::sfep_erase_req_t     o_erase,
   output logic                          o_standby,
   output logic                          o_power_down
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic                      cs_q;
      logic                      sclk_q;
      logic [31:0]               sr;
      logic [7:0]                opcode;
      logic [5:0]                cnt;
      logic [2:0]                id_idx;
      logic                      so;
      logic                      so_oe;
      logic                      write_enable_latch;
      sfep_pkg::sfep_mode_t      mode;
      logic                      erase_go;
      sfep_pkg::sfep_erase_req_t erase;
      logic                      mode_go;
      logic [31:0]               mode_count;
   } sfep_ctrl_state_t;

   sfep_ctrl_state_t st;
   sfep_ctrl_state_t next_st;

   logic        cs_n;
   logic        sclk;
   logic        si;
   logic        erase_busy;
   logic        erase_done;
   logic        mode_done;
   logic        busy;
   logic        id_phase;
   logic [31:0] erase_count;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   sfep_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pin    (i_cs_n),
      .o_level  (cs_n)
   );

   sfep_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pin    (i_sclk),
      .o_level  (sclk)
   );

   sfep_sync #(.RESET_LEVEL(1'b0)) u_sync_si (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pin    (i_si),
      .o_level  (si)
   );

   // ==========================================================
   // Timers
   // ==========================================================
   // Erase duration follows the kind of the accepted request.
   always_comb begin
      unique case (st.erase.kind)
         sfep_pkg::ERASE_SECTOR:  erase_count = 32'(SECTOR_CYCLES);
         sfep_pkg::ERASE_BLOCK32: erase_count = 32'(BLOCK32_CYCLES);
         sfep_pkg::ERASE_BLOCK64: erase_count = 32'(BLOCK64_CYCLES);
         sfep_pkg::ERASE_ARRAY:   erase_count = 32'(ARRAY_CYCLES);
      endcase
   end

   sfep_timer #(.W(32)) u_erase_timer (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_load   (st.erase_go),
      .i_count  (erase_count),
      .o_busy   (erase_busy),
      .o_done   (erase_done)
   );

   sfep_timer #(.W(32)) u_mode_timer (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_load   (st.mode_go),
      .i_count  (st.mode_count),
      .o_busy   (),
      .o_done   (mode_done)
   );

   // ==========================================================
   // Protection check
   // ==========================================================
   // True when an erase unit of 2**lg bytes at addr meets the protected region.
   function automatic logic hits_protection(input logic [23:0] addr,
                                            input int          lg,
                                            input logic [4:0]  bp);
      logic [24:0] s;
      logic [24:0] e;
      logic [24:0] lo;
      logic [24:0] rs;
      int          rl;
      s = ({1'b0, addr} >> lg) << lg;
      s = s & ((25'h000_0001 << sfep_pkg::ARRAY_LOG2) - 25'h000_0001);
      e = s + (25'h000_0001 << lg);
      rl = (bp[4] ? sfep_pkg::PROT_FINE_LOG2 : sfep_pkg::PROT_WIDE_LOG2)
           + int'(bp[2:0]) - 1;
      if (bp[2:0] == sfep_pkg::PROT_ALL || rl > sfep_pkg::ARRAY_LOG2) begin
         rl = sfep_pkg::ARRAY_LOG2;
      end
      rs = 25'h000_0001 << rl;
      lo = bp[3] ? 25'h000_0000
                 : (25'h000_0001 << sfep_pkg::ARRAY_LOG2) - rs;
      return (bp[2:0] != 3'h0) && (s < lo + rs) && (e > lo);
   endfunction

   // ==========================================================
   // Sequencer
   // ==========================================================
   // Any running cycle, ours or another block's, counts as busy.
   assign busy = erase_busy | i_ext_busy;

   // identifier phase after opcode and three dummy bytes.
   // no identifier while a cycle runs.
   assign id_phase = (st.opcode == sfep_pkg::OP_RELEASE_ID) &&
                     (st.cnt >= sfep_pkg::ADDR_FRAME_BITS) && !busy &&
                     (st.mode == sfep_pkg::MODE_NORMAL ||
                      st.mode == sfep_pkg::MODE_POWER_DOWN);

   // Frame shifting, identifier output and command decode at frame end.
   always_comb begin
      next_st = st;
      next_st.cs_q = cs_n;
      next_st.sclk_q = sclk;
      next_st.erase_go = 1'b0;
      next_st.mode_go = 1'b0;
      if (!cs_n) begin
         if (st.cs_q) begin
            next_st.cnt = 6'h00;
            next_st.id_idx = 3'h0;
            next_st.opcode = 8'h00;
         end else if (sclk && !st.sclk_q) begin
            next_st.sr = {st.sr[30:0], si};
            if (st.cnt != sfep_pkg::BIT_COUNT_MAX) begin
               next_st.cnt = st.cnt + 6'h01;
            end
            if (st.cnt == sfep_pkg::OPCODE_BITS - 6'h01) begin
               next_st.opcode = {st.sr[6:0], si};
            end
         end else if (!sclk && st.sclk_q && id_phase) begin
            // index wraps so the identifier repeats.
            next_st.so = DEVICE_ID[3'h7 - st.id_idx];
            next_st.so_oe = 1'b1;
            next_st.id_idx = st.id_idx + 3'h1;
         end
      end else begin
         next_st.so_oe = 1'b0;
         if (!st.cs_q) begin
            unique case (st.mode)
               sfep_pkg::MODE_NORMAL: begin
                  // nothing is decoded while a cycle runs.
                  if (!busy) begin
                     // opcode-only commands need exactly eight bits.
                     if (st.cnt == sfep_pkg::OPCODE_BITS) begin
                        if (st.opcode == sfep_pkg::OP_WRITE_ENABLE) begin
                           next_st.write_enable_latch = 1'b1;
                        end
                        // only with every protect bit zero.
                        if ((st.opcode == sfep_pkg::OP_ARRAY_ERASE_A ||
                             st.opcode == sfep_pkg::OP_ARRAY_ERASE_B) &&
                            st.write_enable_latch && i_protect_bits == 5'h00) begin
                           next_st.erase_go = 1'b1;
                           next_st.erase = '{kind: sfep_pkg::ERASE_ARRAY,
                                             addr: 24'h00_0000};
                           next_st.write_enable_latch = 1'b0;
                        end
                        // mode goes to MODE_ENTER_PD now and to MODE_POWER_DOWN after the entry delay.
                        if (st.opcode == sfep_pkg::OP_POWER_DOWN) begin
                           next_st.mode = sfep_pkg::MODE_ENTER_PD;
                           next_st.mode_go = 1'b1;
                           next_st.mode_count =
                              32'(sfep_pkg::POWER_DOWN_ENTRY_CYCLES);
                        end
                     end
                     // address erases need exactly thirty-two bits.
                     if (st.cnt == sfep_pkg::ADDR_FRAME_BITS && st.write_enable_latch) begin
                        if (st.opcode == sfep_pkg::OP_SECTOR_ERASE &&
                            !hits_protection(st.sr[23:0], sfep_pkg::SECTOR_LOG2,
                                             i_protect_bits)) begin
                           next_st.erase_go = 1'b1;
                           next_st.erase = '{kind: sfep_pkg::ERASE_SECTOR,
                                             addr: st.sr[23:0]};
                           next_st.write_enable_latch = 1'b0;
                        end
                        if (st.opcode == sfep_pkg::OP_BLOCK32_ERASE &&
                            !hits_protection(st.sr[23:0], sfep_pkg::BLOCK32_LOG2,
                                             i_protect_bits)) begin
                           next_st.erase_go = 1'b1;
                           next_st.erase = '{kind: sfep_pkg::ERASE_BLOCK32,
                                             addr: st.sr[23:0]};
                           next_st.write_enable_latch = 1'b0;
                        end
                        if (st.opcode == sfep_pkg::OP_BLOCK64_ERASE &&
                            !hits_protection(st.sr[23:0], sfep_pkg::BLOCK64_LOG2,
                                             i_protect_bits)) begin
                           next_st.erase_go = 1'b1;
                           next_st.erase = '{kind: sfep_pkg::ERASE_BLOCK64,
                                             addr: st.sr[23:0]};
                           next_st.write_enable_latch = 1'b0;
                        end
                     end
                  end
               end
               sfep_pkg::MODE_POWER_DOWN: begin
                  if (st.opcode == sfep_pkg::OP_RELEASE_ID) begin
                     if (st.cnt == sfep_pkg::OPCODE_BITS) begin
                        next_st.mode = sfep_pkg::MODE_RELEASE;
                        next_st.mode_go = 1'b1;
                        next_st.mode_count =
                           32'(sfep_pkg::FIRST_RELEASE_CYCLES);
                     // identify release waits the second delay.
                     end else if (st.cnt >= sfep_pkg::ADDR_FRAME_BITS) begin
                        next_st.mode = sfep_pkg::MODE_RELEASE;
                        next_st.mode_go = 1'b1;
                        next_st.mode_count =
                           32'(sfep_pkg::SECOND_RELEASE_CYCLES);
                     end
                  end
               end
               sfep_pkg::MODE_ENTER_PD, sfep_pkg::MODE_RELEASE: begin
                  next_st.mode = st.mode;
               end
            endcase
         end
      end
      // Timed mode changes complete on the delay's expiry.
      if (mode_done) begin
         if (st.mode == sfep_pkg::MODE_ENTER_PD) begin
            next_st.mode = sfep_pkg::MODE_POWER_DOWN;
         end else if (st.mode == sfep_pkg::MODE_RELEASE) begin
            next_st.mode = sfep_pkg::MODE_NORMAL;
         end
      end
   end

   // reset is power-up and lands in standby unless i_ext_busy is high.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st <= '{cs_q: 1'b1, mode: sfep_pkg::MODE_NORMAL,
                 erase: '{kind: sfep_pkg::ERASE_SECTOR, addr: 24'h00_0000},
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign o_so = st.so;
   assign o_so_oe = st.so_oe;
   assign o_write_enable_latch = st.write_enable_latch;
   // in-progress flag follows the erase timer.
   assign o_in_progress_flag = erase_busy;
   assign o_erase_start = st.erase_go;
   assign o_erase = st.erase;
   // standby when deselected, idle and awake.
   assign o_standby = cs_n && !busy && (st.mode == sfep_pkg::MODE_NORMAL);
   assign o_power_down = (st.mode == sfep_pkg::MODE_POWER_DOWN);

endmodule

// ==== verif/sfep_ctrl_sva.sv ====
// Port checks for the erase and power-down sequencer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module sfep_ctrl_sva (
   input wire logic                      i_clk,
   input wire logic                      i_resetn,
   input wire logic                      i_cs_n,
   input wire logic [4:0]                i_protect_bits,
   input wire logic                      o_so_oe,
   input wire logic                      o_write_enable_latch,
   input wire logic                      o_in_progress_flag,
   input wire logic                      o_erase_start,
   input wire sfep_pkg::sfep_erase_req_t o_erase,
   input wire logic                      o_standby,
   input wire logic                      o_power_down
);
   logic [9:0] quiet;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Counts cycles spent out of standby, so early power-down entry shows.
   always_ff @(posedge i_clk) begin
      if (!i_resetn || o_standby || o_power_down) begin
         quiet <= 10'h000;
      end else if (quiet != 10'h3FF) begin
         quiet <= quiet + 10'h001;
      end
   end
   // ==========================================================
   // Assertions
   property p_clr; o_erase_start |-> !o_write_enable_latch; endproperty
   a_clr: assert property (p_clr) else $error("latch kept at erase start");
   property p_run; o_erase_start |=> o_in_progress_flag; endproperty
   a_run: assert property (p_run) else $error("busy flag missing after start");
   property p_hold; $rose(o_in_progress_flag) |-> o_in_progress_flag [*8]; endproperty
   a_hold: assert property (p_hold) else $error("busy flag dropped early");
   property p_latch; o_erase_start |-> $past(o_write_enable_latch); endproperty
   a_latch: assert property (p_latch) else $error("erase started without latch");
   property p_arr; o_erase_start && o_erase.kind == sfep_pkg::ERASE_ARRAY
      |-> $past(i_protect_bits) == 5'h00; endproperty
   a_arr: assert property (p_arr) else $error("array erase under protection");
   property p_dly; $rose(o_power_down) |-> quiet >= 10'h12C; endproperty
   a_dly: assert property (p_dly) else $error("power-down entered too early");
   property p_pd; o_power_down |-> !o_in_progress_flag && !o_standby; endproperty
   a_pd: assert property (p_pd) else $error("power-down with busy or standby");
   property p_busy; o_in_progress_flag |-> !o_erase_start; endproperty
   a_busy: assert property (p_busy) else $error("command taken while busy");
   property p_oe; i_cs_n [*8] |-> !o_so_oe; endproperty
   a_oe: assert property (p_oe) else $error("output driven while deselected");
   c_erase: cover property (o_erase_start);
   c_pd: cover property ($rose(o_power_down));
   c_id: cover property ($rose(o_so_oe));
endmodule
bind sfep_ctrl sfep_ctrl_sva i_sfep_ctrl_sva (.i_clk, .i_resetn, .i_cs_n, .i_protect_bits,
   .o_so_oe, .o_write_enable_latch, .o_in_progress_flag, .o_erase_start, .o_erase,
   .o_standby, .o_power_down);

// ==== verif/sfep_host_model.sv ====
// Host model: a mode-0 serial master that frames commands bit by bit.
// Assumes the device samples these pins with its own faster clock.
`timescale 1ns/1ps
module sfep_host_model (
   output logic        o_sclk,
   output logic        o_cs_n,
   output logic        o_si,
   input  wire logic   i_so,
   output logic [15:0] o_rx
);
   // Link idles with select high and the clock low.
   initial begin
      o_sclk <= 1'b0;
      o_cs_n <= 1'b1;
      o_si <= 1'b0;
      o_rx <= 16'h0000;
   end
   // ==========================================================
   // Frame task
   // select framing.
   // Sends n bits MSB first at 125 ns a bit, keeping the last 16 bits read back.
   task automatic frame(input logic [63:0] w, input int n);
      // Non-blocking updates keep pin changes that land on a clock edge race-free.
      o_cs_n <= 1'b0;
      for (int k = n - 1; k >= 0; k--) begin
         o_si <= w[k];
         #62.5 o_rx <= {o_rx[14:0], i_so};
         o_sclk <= 1'b1;
         #62.5 o_sclk <= 1'b0;
      end
      #62.5 o_cs_n <= 1'b1;
      o_si <= ~o_si;
      #300;
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the erase and power-down sequencer.
// Assumes the host model drives the serial pins and the checker is bound.
`timescale 1ns/1ps
module tb_top;
   logic                      i_clk = 1'b0;
   logic                      i_resetn = 1'b0;
   logic [4:0]                i_protect_bits = 5'h00;
   logic                      i_ext_busy = 1'b0;
   logic                      i_sclk, i_cs_n, i_si, o_so, o_so_oe, o_standby, o_power_down;
   logic                      o_write_enable_latch, o_in_progress_flag, o_erase_start;
   logic [15:0]               rx;
   sfep_pkg::sfep_erase_req_t o_erase;
   int                        errors = 0, samples_checked = 0, starts = 0, busy_len = 0;
   // Free-running 100 MHz clock.
   always #5 i_clk = ~i_clk;
   sfep_ctrl #(.SECTOR_CYCLES(50), .BLOCK32_CYCLES(60), .BLOCK64_CYCLES(70),
      .ARRAY_CYCLES(2000)) i_sfep_ctrl (.i_clk, .i_resetn, .i_sclk, .i_cs_n, .i_si, .o_so,
      .o_so_oe, .i_protect_bits, .i_ext_busy, .o_write_enable_latch, .o_in_progress_flag,
      .o_erase_start, .o_erase, .o_standby, .o_power_down);
   // A released output reads back inverted, so bits sent without enable fail.
   sfep_host_model u_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si),
      .i_so(o_so_oe ? o_so : !o_so), .o_rx(rx));
   // Counts accepted erases and busy cycles.
   always @(posedge i_clk) begin
      if (o_erase_start === 1'b1) starts++;
      if (o_in_progress_flag === 1'b1) busy_len++;
   end
   // ==========================================================
   // Tasks
   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic close_out;
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Sets the latch, sends one erase frame and checks whether it ran.
   task automatic erase(input logic [63:0] w, input int n, input logic [25:0] req,
                        input int len, input logic ok);
      int s;
      s = starts;
      busy_len = 0;
      u_host.frame(64'h06, 8);
      u_host.frame(w, n);
      repeat (len + 20) @(posedge i_clk);
      chk(starts - s, {31'h0000_0000, ok});
      chk(o_write_enable_latch, {31'h0000_0000, !ok});
      if (ok) begin
         chk(o_erase, req);
         chk(busy_len, len);
      end
   endtask
   // ==========================================================
   // Tests
   initial begin
      repeat (16) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk({o_standby, o_power_down, o_write_enable_latch, o_in_progress_flag}, 4'h8);
      u_host.frame({8'hAB, 40'h00_0000_0000}, 48);
      chk({rx, o_power_down, o_standby}, {{2{sfep_pkg::DEVICE_ID_DEFAULT}}, 2'h1});
      u_host.frame({8'h20, 24'h00_1000}, 32);
      chk(starts, 0);
      erase({8'h20, 24'h12_3456}, 32, {sfep_pkg::ERASE_SECTOR, 24'h12_3456}, 50, 1);
      erase({8'h52, 24'h0A_BCDE}, 32, {sfep_pkg::ERASE_BLOCK32, 24'h0A_BCDE}, 60, 1);
      erase({8'hD8, 24'h1F_FFFF}, 32, {sfep_pkg::ERASE_BLOCK64, 24'h1F_FFFF}, 70, 1);
      erase(64'h60, 8, {sfep_pkg::ERASE_ARRAY, 24'h00_0000}, 2000, 1);
      erase(64'hC7, 8, {sfep_pkg::ERASE_ARRAY, 24'h00_0000}, 2000, 1);
      erase({8'h20, 24'h00_1000, 1'b0}, 33, 0, 0, 0);
      erase(64'h1000_0800, 31, 0, 0, 0);
      erase({8'hC7, 1'b0}, 9, 0, 0, 0);
      @(posedge i_clk) i_protect_bits <= 5'h01;
      erase({8'h20, 24'h1F_0000}, 32, 0, 0, 0);
      erase({8'h52, 24'h1F_8000}, 32, 0, 0, 0);
      erase(64'h60, 8, 0, 0, 0);
      erase({8'h20, 24'h00_0000}, 32, {sfep_pkg::ERASE_SECTOR, 24'h00_0000}, 50, 1);
      @(posedge i_clk) i_protect_bits <= 5'h09;
      erase({8'hD8, 24'h00_8000}, 32, 0, 0, 0);
      @(posedge i_clk) i_protect_bits <= 5'h00;
      @(posedge i_clk) i_ext_busy <= 1'b1;
      u_host.frame(64'hB9, 8);
      repeat (320) @(posedge i_clk);
      chk(o_power_down, 0);
      @(posedge i_clk) i_ext_busy <= 1'b0;
      u_host.frame(64'h06, 8);
      u_host.frame(64'h60, 8);
      u_host.frame(64'hB9, 8);
      u_host.frame({8'hAB, 32'h0000_0000}, 40);
      chk({o_power_down, o_so_oe, o_in_progress_flag}, 3'h1);
      repeat (2000) @(posedge i_clk);
      chk(o_power_down, 0);
      u_host.frame(64'hB9, 8);
      chk(o_power_down, 0);
      repeat (300) @(posedge i_clk);
      chk(o_power_down, 1);
      u_host.frame(64'h06, 8);
      chk(o_write_enable_latch, 0);
      u_host.frame(64'hAB, 8);
      chk({o_power_down, o_standby}, 2'h0);
      repeat (300) @(posedge i_clk);
      chk({o_power_down, o_standby}, 2'h1);
      u_host.frame(64'hB9, 8);
      repeat (300) @(posedge i_clk);
      u_host.frame({8'hAB, 40'h00_0000_0000}, 48);
      chk(rx, {2{sfep_pkg::DEVICE_ID_DEFAULT}});
      repeat (300) @(posedge i_clk);
      chk({o_power_down, o_standby, o_so_oe}, 3'h2);
      close_out();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      #1ms;
      errors++;
      close_out();
   end
endmodule
